// *** verilog/emp_pins.sv ***
// External memory pin interface: SDRAM command pins, I/O bank selects, shared data bus
//
// Contract
// RL1 - 32-bit two-way data bus, driven on writes, sampled on reads.
// RL2 - Bus may also run 8 or 16 bits wide.
// RL3 - Two SDRAM banks, each with its own active-low select.
// RL4 - Drive active-low SDRAM row strobe with commands.
// RL5 - Drive active-low SDRAM column strobe with commands.
// RL6 - Drive active-low SDRAM write enable for write-type commands.
// RL7 - SDRAM byte masks mask writes and gate read output; high means masked.
// RL8 - SDRAM ignores write bytes whose mask is driven high.
// RL9 - Mask bits 0..3 govern data lanes 7:0, 15:8, 23:16, 31:24.
// RL10 - Three external I/O banks, each with its own select.
// RL11 - Each I/O bank spans at most 16KB.
// RL12 - Assert low the select of the targeted I/O bank.
// RL13 - Slow device asserts wait low; access is extended meanwhile.
// RL14 - At most one select of each kind asserted; all deasserted when idle.
`default_nettype none
module emp_pins #(
    parameter int unsigned SD_READ_LAT = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire emp_pkg::emp_width_t cfg_bus_width_i,
    input wire logic [emp_pkg::CYCLES_W-1:0] cfg_io_cycles_i,
    input wire logic req_valid_i,
    input wire emp_pkg::emp_req_t req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [emp_pkg::DATA_W-1:0] rsp_rdata_o,
    input wire logic [emp_pkg::DATA_W-1:0] external_data_bus_i,
    output logic [emp_pkg::DATA_W-1:0] external_data_bus_o,
    output logic [emp_pkg::LANES-1:0] external_data_bus_oe_n_o,
    output logic [emp_pkg::SD_BANKS-1:0] sdram_bank_select_n_o,
    output logic sdram_row_strobe_n_o,
    output logic sdram_column_strobe_n_o,
    output logic sdram_write_enable_n_o,
    output logic [emp_pkg::LANES-1:0] sdram_byte_mask_o,
    output logic [emp_pkg::IO_BANKS-1:0] io_bank_select_n_o,
    output logic [emp_pkg::IO_OFFSET_W-1:0] io_offset_o,
    input wire logic external_wait_n_i
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EMP_IDLE,
        EMP_SD_CMD,
        EMP_SD_READ,
        EMP_IO_ACC,
        EMP_IO_CAP
    } emp_state_t;

    typedef struct packed {
        emp_state_t state;
        emp_pkg::emp_req_t req;
        emp_pkg::emp_width_t width;
        logic [emp_pkg::CYCLES_W-1:0] count;
        logic [emp_pkg::BEAT_W-1:0] beat;
        logic ready;
        logic rsp_valid;
        logic [emp_pkg::DATA_W-1:0] rdata;
        logic [emp_pkg::DATA_W-1:0] dout;
        logic [emp_pkg::LANES-1:0] oe_n;
        logic [emp_pkg::SD_BANKS-1:0] sd_sel_n;
        emp_pkg::emp_sd_cmd_t sd_cmd;
        logic [emp_pkg::LANES-1:0] mask;
        logic [emp_pkg::IO_BANKS-1:0] io_sel_n;
        logic [emp_pkg::IO_OFFSET_W-1:0] offset;
    } emp_pins_st_t;

    localparam logic [emp_pkg::CYCLES_W-1:0] SD_LAT_CNT =
        emp_pkg::CYCLES_W'(SD_READ_LAT + emp_pkg::SYNC_STAGES - 1);

    emp_pins_st_t st_q;
    emp_pins_st_t st_d;

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic [emp_pkg::DATA_W-1:0] data_sync;
    logic wait_n_sync;

    emp_sync #(
        .WIDTH(emp_pkg::DATA_W),
        .RESET_VAL(emp_pkg::DATA_RST)
    ) u_data_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .async_i(external_data_bus_i),
        .sync_o(data_sync)
    );

    emp_sync #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_wait_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .async_i(external_wait_n_i),
        .sync_o(wait_n_sync)
    );

    // ------------------------------------------------------------
    // Beat placement
    // ------------------------------------------------------------
    logic idle;
    emp_pkg::emp_width_t beat_width;
    logic [emp_pkg::BEAT_W-1:0] beat_sel;
    logic [emp_pkg::DATA_W-1:0] beat_word;
    logic [emp_pkg::LANES-1:0] beat_be;
    logic [emp_pkg::DATA_W-1:0] beat_data;
    logic [emp_pkg::LANES-1:0] beat_en;
    logic [emp_pkg::BEAT_W-1:0] last_beat;

    assign idle = (st_q.state == EMP_IDLE);
    // Width is latched per access so a config change never splits a word oddly
    assign beat_width = idle ? cfg_bus_width_i : st_q.width;
    assign beat_sel = idle ? emp_pkg::BEAT_RST : st_q.beat + 2'h1;
    assign beat_word = idle ? req_i.wdata : st_q.req.wdata;
    assign beat_be = idle ? req_i.byte_en : st_q.req.byte_en;

    emp_beat u_beat (
        .width_i(beat_width),
        .beat_i(beat_sel),
        .word_i(beat_word),
        .byte_en_i(beat_be),
        .lane_data_o(beat_data),
        .lane_en_o(beat_en)
    );

    always_comb begin
        case (st_q.width)
            emp_pkg::EMP_W8: last_beat = emp_pkg::BEATS_W8;
            emp_pkg::EMP_W16: last_beat = emp_pkg::BEATS_W16;
            default: last_beat = emp_pkg::BEATS_W32;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;
        case (st_q.state)
            EMP_IDLE: begin
                if (req_valid_i) begin
                    st_d.req = req_i;
                    st_d.width = cfg_bus_width_i;
                    st_d.beat = emp_pkg::BEAT_RST;
                    st_d.ready = 1'b0;
                    if (req_i.target == emp_pkg::EMP_TGT_SDRAM) begin
                        // SDRAM words always use the full bus, one lane per mask bit
                        st_d.state = EMP_SD_CMD;
                        st_d.sd_sel_n = emp_pkg::SD_SEL_IDLE;
                        st_d.sd_sel_n[req_i.sd_bank] = 1'b0; // RL3 RL14
                        st_d.sd_cmd = req_i.sd_cmd; // RL4 RL5 RL6
                        st_d.mask = ~req_i.byte_en; // RL7 RL8 RL9
                        if (req_i.write) begin
                            st_d.dout = req_i.wdata; // RL1
                            st_d.oe_n = ~req_i.byte_en; // RL1
                        end
                    end else begin
                        st_d.state = EMP_IO_ACC;
                        st_d.count = cfg_io_cycles_i;
                        st_d.io_sel_n = emp_pkg::IO_SEL_IDLE;
                        if (req_i.io_bank < 2'(emp_pkg::IO_BANKS)) begin
                            st_d.io_sel_n[req_i.io_bank] = 1'b0; // RL10 RL12 RL14
                        end
                        st_d.offset = req_i.io_offset; // RL11
                        if (req_i.write) begin
                            st_d.dout = beat_data; // RL1 RL2
                            st_d.oe_n = ~beat_en;
                        end
                    end
                end
            end
            EMP_SD_CMD: begin
                // Command pins are asserted for exactly one cycle
                st_d.sd_sel_n = emp_pkg::SD_SEL_IDLE; // RL14
                st_d.sd_cmd = emp_pkg::SD_CMD_IDLE;
                st_d.oe_n = emp_pkg::OE_N_IDLE;
                if (st_q.req.write) begin
                    st_d.mask = emp_pkg::MASK_IDLE;
                    st_d.state = EMP_IDLE;
                    st_d.ready = 1'b1;
                    st_d.rsp_valid = 1'b1;
                end else begin
                    // Masks stay low as read output enables until data lands
                    st_d.state = EMP_SD_READ; // RL7
                    st_d.count = SD_LAT_CNT;
                end
            end
            EMP_SD_READ: begin
                if (st_q.count != emp_pkg::COUNT_RST) begin
                    st_d.count = st_q.count - 4'h1;
                end else begin
                    st_d.rdata = data_sync; // RL1
                    st_d.mask = emp_pkg::MASK_IDLE;
                    st_d.state = EMP_IDLE;
                    st_d.ready = 1'b1;
                    st_d.rsp_valid = 1'b1;
                end
            end
            EMP_IO_ACC: begin
                if (st_q.count != emp_pkg::COUNT_RST) begin
                    st_d.count = st_q.count - 4'h1;
                end else if (!wait_n_sync) begin
                    // Wait is seen two cycles late through its synchroniser
                    st_d.count = emp_pkg::COUNT_RST; // RL13
                end else if (!st_q.req.write) begin
                    st_d.state = EMP_IO_CAP;
                    st_d.count = emp_pkg::SYNC_HOLD;
                end else if (st_q.beat == last_beat) begin
                    st_d.io_sel_n = emp_pkg::IO_SEL_IDLE; // RL14
                    st_d.oe_n = emp_pkg::OE_N_IDLE;
                    st_d.state = EMP_IDLE;
                    st_d.ready = 1'b1;
                    st_d.rsp_valid = 1'b1;
                end else begin
                    st_d.beat = beat_sel;
                    st_d.dout = beat_data; // RL2
                    st_d.oe_n = ~beat_en;
                    st_d.count = cfg_io_cycles_i;
                end
            end
            EMP_IO_CAP: begin
                // Select stays asserted while read data crosses the synchroniser
                if (st_q.count != emp_pkg::COUNT_RST) begin
                    st_d.count = st_q.count - 4'h1;
                end else begin
                    case (st_q.width)
                        emp_pkg::EMP_W8: st_d.rdata[st_q.beat*8 +: 8] = data_sync[7:0]; // RL2
                        emp_pkg::EMP_W16: begin
                            st_d.rdata[st_q.beat[0]*16 +: 16] = data_sync[15:0]; // RL2
                        end
                        default: st_d.rdata = data_sync; // RL1
                    endcase
                    if (st_q.beat == last_beat) begin
                        st_d.io_sel_n = emp_pkg::IO_SEL_IDLE; // RL14
                        st_d.state = EMP_IDLE;
                        st_d.ready = 1'b1;
                        st_d.rsp_valid = 1'b1;
                    end else begin
                        st_d.beat = beat_sel;
                        st_d.state = EMP_IO_ACC;
                        st_d.count = cfg_io_cycles_i;
                    end
                end
            end
            default: begin
                st_d.state = EMP_IDLE;
                st_d.ready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q.state <= EMP_IDLE;
            st_q.req <= '0;
            st_q.width <= emp_pkg::EMP_W32;
            st_q.count <= emp_pkg::COUNT_RST;
            st_q.beat <= emp_pkg::BEAT_RST;
            st_q.ready <= 1'b1;
            st_q.rsp_valid <= 1'b0;
            st_q.rdata <= emp_pkg::DATA_RST;
            st_q.dout <= emp_pkg::DATA_RST;
            st_q.oe_n <= emp_pkg::OE_N_IDLE;
            st_q.sd_sel_n <= emp_pkg::SD_SEL_IDLE;
            st_q.sd_cmd <= emp_pkg::SD_CMD_IDLE;
            st_q.mask <= emp_pkg::MASK_IDLE;
            st_q.io_sel_n <= emp_pkg::IO_SEL_IDLE;
            st_q.offset <= emp_pkg::OFFSET_RST;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready_o = st_q.ready;
    assign rsp_valid_o = st_q.rsp_valid;
    assign rsp_rdata_o = st_q.rdata;
    assign external_data_bus_o = st_q.dout;
    assign external_data_bus_oe_n_o = st_q.oe_n;
    assign sdram_bank_select_n_o = st_q.sd_sel_n;
    assign sdram_row_strobe_n_o = st_q.sd_cmd.row_n;
    assign sdram_column_strobe_n_o = st_q.sd_cmd.col_n;
    assign sdram_write_enable_n_o = st_q.sd_cmd.we_n;
    assign sdram_byte_mask_o = st_q.mask;
    assign io_bank_select_n_o = st_q.io_sel_n;
    assign io_offset_o = st_q.offset;
endmodule : emp_pins
`default_nettype wire

// *** inc/emp_pkg.sv ***
// Package of constants and carrier types for the external memory pin interface
`default_nettype none
package emp_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned LANES = 4;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned SD_BANKS = 2;
    localparam int unsigned IO_BANKS = 3;
    localparam int unsigned IO_BANK_IDX_W = 2;
    localparam int unsigned IO_SPAN_BYTES = 16384;
    localparam int unsigned IO_OFFSET_W = $clog2(IO_SPAN_BYTES);
    localparam int unsigned CYCLES_W = 4;
    localparam int unsigned BEAT_W = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Idle and reset levels of the pins
    // ------------------------------------------------------------
    localparam logic [SD_BANKS-1:0] SD_SEL_IDLE = 2'h3;
    localparam logic [IO_BANKS-1:0] IO_SEL_IDLE = 3'h7;
    localparam logic [LANES-1:0] MASK_IDLE = 4'hf;
    localparam logic [LANES-1:0] OE_N_IDLE = 4'hf;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0;
    localparam logic [IO_OFFSET_W-1:0] OFFSET_RST = 14'h0;
    localparam logic [CYCLES_W-1:0] COUNT_RST = 4'h0;
    localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
    localparam logic [BEAT_W-1:0] BEATS_W8 = 2'h3;
    localparam logic [BEAT_W-1:0] BEATS_W16 = 2'h1;
    localparam logic [BEAT_W-1:0] BEATS_W32 = 2'h0;
    localparam logic [CYCLES_W-1:0] SYNC_HOLD = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EMP_W8,
        EMP_W16,
        EMP_W32
    } emp_width_t;

    typedef enum logic {
        EMP_TGT_SDRAM,
        EMP_TGT_IO
    } emp_target_t;

    // Row strobe, column strobe, write enable; low = asserted
    typedef struct packed {
        logic row_n;
        logic col_n;
        logic we_n;
    } emp_sd_cmd_t;

    typedef struct packed {
        emp_target_t target;
        logic write;
        logic sd_bank;
        emp_sd_cmd_t sd_cmd;
        logic [IO_BANK_IDX_W-1:0] io_bank;
        logic [IO_OFFSET_W-1:0] io_offset;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0] byte_en;
    } emp_req_t;

    localparam emp_sd_cmd_t SD_CMD_IDLE = 3'h7;
endpackage : emp_pkg
`default_nettype wire

// *** verilog/emp_sync.sv ***
// Two-stage synchroniser for pin inputs, frozen by the clock enable
`default_nettype none
module emp_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } emp_sync_st_t;

    emp_sync_st_t st_q;
    emp_sync_st_t st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d.meta = async_i;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= {RESET_VAL, RESET_VAL};
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stable;
endmodule : emp_sync
`default_nettype wire

// *** verilog/emp_beat.sv ***
// Places one beat of a word onto the byte lanes for the configured bus width
`default_nettype none
module emp_beat (
    input wire emp_pkg::emp_width_t width_i,
    input wire logic [emp_pkg::BEAT_W-1:0] beat_i,
    input wire logic [emp_pkg::DATA_W-1:0] word_i,
    input wire logic [emp_pkg::LANES-1:0] byte_en_i,
    output logic [emp_pkg::DATA_W-1:0] lane_data_o,
    output logic [emp_pkg::LANES-1:0] lane_en_o
);
    // Narrow widths move the selected bytes down to the low lanes
    always_comb begin
        lane_data_o = '0;
        lane_en_o = '0;
        case (width_i)
            emp_pkg::EMP_W8: begin
                lane_data_o[7:0] = word_i[beat_i*8 +: 8];
                lane_en_o[0] = byte_en_i[beat_i];
            end
            emp_pkg::EMP_W16: begin
                lane_data_o[15:0] = word_i[beat_i[0]*16 +: 16];
                lane_en_o[1:0] = byte_en_i[beat_i[0]*2 +: 2];
            end
            default: begin
                lane_data_o = word_i;
                lane_en_o = byte_en_i;
            end
        endcase
    end
endmodule : emp_beat
`default_nettype wire

// *** bench/emp_pins_sva.sv ***
// Concurrent checks on the ports of the external memory pin interface
`default_nettype none
module emp_pins_sva #(
    parameter int unsigned SD_READ_LAT = 2
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic req_valid_i,
    input wire emp_pkg::emp_req_t req_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [emp_pkg::SD_BANKS-1:0] sdram_bank_select_n_o,
    input wire logic sdram_row_strobe_n_o,
    input wire logic sdram_column_strobe_n_o,
    input wire logic sdram_write_enable_n_o,
    input wire logic [emp_pkg::LANES-1:0] sdram_byte_mask_o,
    input wire logic [emp_pkg::IO_BANKS-1:0] io_bank_select_n_o,
    input wire logic [emp_pkg::IO_OFFSET_W-1:0] io_offset_o,
    input wire logic external_wait_n_i
);
    // ----
    // Taken requests
    // ----
    localparam int RD_LAT = SD_READ_LAT + 4;
    wire logic take = clk_en_i && req_valid_i && req_ready_o;
    wire logic take_sd = take && req_i.target == emp_pkg::EMP_TGT_SDRAM;
    wire logic take_io = take && req_i.target == emp_pkg::EMP_TGT_IO;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sd_onehot_a: assert property ($countones(~sdram_bank_select_n_o) <= 1)
        else $error("two SDRAM banks selected");
    io_onehot_a: assert property ($countones(~io_bank_select_n_o) <= 1)
        else $error("two I/O banks selected");
    idle_sel_a: assert property (req_ready_o |-> sdram_bank_select_n_o == emp_pkg::SD_SEL_IDLE
        && io_bank_select_n_o == emp_pkg::IO_SEL_IDLE) else $error("select active while idle");
    sd_sel_a: assert property (take_sd |=>
        sdram_bank_select_n_o == ~(2'h1 << $past(req_i.sd_bank))) else $error("wrong SDRAM bank");
    sd_cmd_a: assert property (take_sd |=>
        {sdram_row_strobe_n_o, sdram_column_strobe_n_o, sdram_write_enable_n_o}
        == $past(req_i.sd_cmd)) else $error("SDRAM strobes differ from command");
    sd_mask_a: assert property (take_sd |=>
        sdram_byte_mask_o == ~$past(req_i.byte_en)) else $error("byte mask wrong");
    sd_wr_rsp_a: assert property (take_sd && req_i.write |-> ##1 !rsp_valid_o ##1 rsp_valid_o)
        else $error("SDRAM write response late");
    sd_rd_rsp_a: assert property (take_sd && !req_i.write |-> ##RD_LAT rsp_valid_o)
        else $error("SDRAM read response late");
    io_sel_a: assert property (take_io && req_i.io_bank != 2'h3 |=>
        io_bank_select_n_o == ~(3'h1 << $past(req_i.io_bank))) else $error("wrong I/O bank");
    io_none_a: assert property (take_io && req_i.io_bank == 2'h3 |=>
        io_bank_select_n_o == emp_pkg::IO_SEL_IDLE) else $error("unmapped bank selected");
    io_offset_a: assert property (take_io |=> io_offset_o == $past(req_i.io_offset))
        else $error("I/O offset not passed");

    sd_wr_c: cover property (take_sd && req_i.write);
    sd_rd_c: cover property (take_sd && !req_i.write);
    io_wait_c: cover property (take_io && !external_wait_n_i);
endmodule : emp_pins_sva

bind emp_pins emp_pins_sva #(.SD_READ_LAT(SD_READ_LAT)) u_sva (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .sdram_bank_select_n_o(sdram_bank_select_n_o), .sdram_row_strobe_n_o(sdram_row_strobe_n_o),
    .sdram_column_strobe_n_o(sdram_column_strobe_n_o),
    .sdram_write_enable_n_o(sdram_write_enable_n_o), .sdram_byte_mask_o(sdram_byte_mask_o),
    .io_bank_select_n_o(io_bank_select_n_o), .io_offset_o(io_offset_o),
    .external_wait_n_i(external_wait_n_i));
`default_nettype wire

// *** bench/emp_far_model.sv ***
// Behavioural SDRAM banks and I/O devices on the far side of the pins
`default_nettype none
module emp_far_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic [31:0] bus_drive_i,
    input wire logic [3:0] bus_oe_n_i,
    input wire logic [1:0] sd_sel_n_i,
    input wire logic sd_col_n_i,
    input wire logic sd_we_n_i,
    input wire logic [3:0] sd_mask_i,
    input wire logic [2:0] io_sel_n_i,
    output logic [31:0] bus_o,
    output logic wait_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] sd_mem [2] = '{default: 32'h0};
    logic [31:0] io_mem [3] = '{default: 32'h0};
    logic [31:0] last_q = 32'h0;
    logic sd_b = 1'b0;
    wire logic [1:0] io_b = io_sel_n_i[0] ? (io_sel_n_i[1] ? 2'h2 : 2'h1) : 2'h0;

    assign wait_n_o = !stall_i;

    // ----
    // Wire level per lane
    // ----
    // An undriven lane toggles so a stale value never looks like read data
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            if (!bus_oe_n_i[l]) begin
                bus_o[l*8 +: 8] = bus_drive_i[l*8 +: 8];
            end else if (!sd_mask_i[l]) begin
                bus_o[l*8 +: 8] = sd_mem[sd_b][l*8 +: 8];
            end else if (io_sel_n_i != 3'h7) begin
                bus_o[l*8 +: 8] = io_mem[io_b][l*8 +: 8];
            end else begin
                bus_o[l*8 +: 8] = ~last_q[l*8 +: 8];
            end
        end
    end

    always @(posedge clk_i) begin
        last_q <= bus_o;
        if (sd_sel_n_i != 2'h3) begin
            sd_b <= sd_sel_n_i[0];
        end
        for (int l = 0; l < 4; l++) begin
            if (sd_sel_n_i != 2'h3 && !sd_col_n_i && !sd_we_n_i && !sd_mask_i[l]) begin
                sd_mem[sd_sel_n_i[0]][l*8 +: 8] <= bus_drive_i[l*8 +: 8];
            end
            if (io_sel_n_i != 3'h7 && !bus_oe_n_i[l]) begin
                io_mem[io_b][l*8 +: 8] <= bus_drive_i[l*8 +: 8];
            end
        end
    end
endmodule : emp_far_model
`default_nettype wire

// *** bench/emp_pins_tb.sv ***
// Self-checking bench for the external memory pin interface
`default_nettype none
module emp_pins_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD_LAT = 2;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    emp_pkg::emp_width_t cfg_w = emp_pkg::EMP_W32;
    logic [3:0] cfg_cyc = 4'h2;
    logic req_valid = 1'b0;
    emp_pkg::emp_req_t req = '0;
    logic stall = 1'b0;
    logic ready, rsp_valid, row_n, col_n, we_n, wait_n;
    logic [31:0] rdata, din, dout;
    logic [31:0] dq [32];
    logic [3:0] oe_n, mask;
    logic [1:0] sd_sel;
    logic [2:0] io_sel;
    int errors = 0;
    int checks = 0;

    always #20 clk_i = ~clk_i;

    emp_pins #(.SD_READ_LAT(RD_LAT)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .cfg_bus_width_i(cfg_w), .cfg_io_cycles_i(cfg_cyc), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata),
        .external_data_bus_i(din), .external_data_bus_o(dout), .external_data_bus_oe_n_o(oe_n),
        .sdram_bank_select_n_o(sd_sel), .sdram_row_strobe_n_o(row_n),
        .sdram_column_strobe_n_o(col_n), .sdram_write_enable_n_o(we_n),
        .sdram_byte_mask_o(mask), .io_bank_select_n_o(io_sel), .io_offset_o(),
        .external_wait_n_i(wait_n));

    emp_far_model FAR (.clk_i(clk_i), .stall_i(stall), .bus_drive_i(dout), .bus_oe_n_i(oe_n),
        .sd_sel_n_i(sd_sel), .sd_col_n_i(col_n), .sd_we_n_i(we_n), .sd_mask_i(mask),
        .io_sel_n_i(io_sel), .bus_o(din), .wait_n_o(wait_n));

    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    function automatic emp_pkg::emp_req_t sd(input logic b, input logic w, input logic [3:0] be,
                                            input logic [31:0] d);
        return '{target: emp_pkg::EMP_TGT_SDRAM, write: w, sd_bank: b,
                 sd_cmd: emp_pkg::emp_sd_cmd_t'({1'b1, 1'b0, !w}), io_bank: 2'h0,
                 io_offset: 14'h0, wdata: d, byte_en: be};
    endfunction : sd

    function automatic emp_pkg::emp_req_t io(input logic [1:0] b, input logic w,
                                            input logic [13:0] o, input logic [31:0] d);
        return '{target: emp_pkg::EMP_TGT_IO, write: w, sd_bank: 1'b0,
                 sd_cmd: emp_pkg::SD_CMD_IDLE, io_bank: b, io_offset: o, wdata: d, byte_en: 4'hf};
    endfunction : io

    // Entered on a falling edge while idle; returns on the falling edge that shows the response
    task automatic issue(input emp_pkg::emp_req_t r, output logic [31:0] lat);
        req = r;
        req_valid = 1'b1;
        @(negedge clk_i);
        req_valid = 1'b0;
        lat = 32'h1;
        dq[1] = dout;
        while (!rsp_valid && lat < 32'd40) begin
            @(negedge clk_i);
            lat++;
            dq[lat[4:0]] = dout;
        end
    endtask : issue

    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        check({27'h0, sd_sel, io_sel}, 32'h1f);
        check({24'h0, mask, oe_n}, 32'hff);
        check({31'h0, ready}, 32'h1);
    endtask : t_reset

    task automatic t_sdram();
        logic [31:0] lat;
        for (int b = 0; b < 2; b++) begin
            issue(sd(b[0], 1'b1, 4'hf, 32'h1122_3344), lat);
            check(lat, 32'h2);
            check(dq[1], 32'h1122_3344);
            issue(sd(b[0], 1'b1, 4'h5, 32'haabb_ccd0 | b), lat);
            issue(sd(b[0], 1'b0, 4'hf, 32'h0), lat);
            check(lat, RD_LAT + 4);
            check(rdata, 32'h11bb_33d0 | b);
        end
        issue(sd(1'b0, 1'b0, 4'hf, 32'h0), lat);
        check(rdata, 32'h11bb_33d0);
    endtask : t_sdram

    task automatic t_io();
        logic [31:0] lat;
        for (int b = 0; b < 3; b++) begin
            issue(io(b[1:0], 1'b1, 14'h3fff, 32'h5a00_0000 | b), lat);
            check(lat, cfg_cyc + 32'h2);
            check(dq[1], 32'h5a00_0000 | b);
        end
        issue(io(2'h3, 1'b1, 14'h0, 32'h0), lat);
        for (int b = 0; b < 3; b++) begin
            issue(io(b[1:0], 1'b0, 14'h3fff, 32'h0), lat);
            check(lat, cfg_cyc + 32'h4);
            check(rdata, 32'h5a00_0000 | b);
        end
    endtask : t_io

    task automatic t_wait();
        logic [31:0] lat;
        stall = 1'b1;
        fork
            issue(io(2'h1, 1'b1, 14'h10, 32'h0bad_cafe), lat);
            begin
                repeat (10) @(negedge clk_i);
                stall = 1'b0;
            end
        join
        check({31'h0, lat >= 32'd12}, 32'h1);
        issue(io(2'h1, 1'b0, 14'h10, 32'h0), lat);
        check(rdata, 32'h0bad_cafe);
    endtask : t_wait

    task automatic t_narrow();
        logic [31:0] lat;
        logic [31:0] w;
        w = 32'h89ab_cdef;
        cfg_cyc = 4'h1;
        cfg_w = emp_pkg::EMP_W16;
        issue(io(2'h0, 1'b1, 14'h0, w), lat);
        check(lat, 32'h5);
        check({16'h0, dq[1][15:0]}, {16'h0, w[15:0]});
        check({16'h0, dq[3][15:0]}, {16'h0, w[31:16]});
        cfg_w = emp_pkg::EMP_W8;
        issue(io(2'h0, 1'b1, 14'h0, w), lat);
        check(lat, 32'h9);
        for (int k = 0; k < 4; k++) begin
            check({24'h0, dq[1+2*k][7:0]}, {24'h0, w[k*8 +: 8]});
        end
        cfg_w = emp_pkg::EMP_W32;
    endtask : t_narrow

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Whole run is about a hundred cycles; this margin only catches a hang
    initial begin
        #(40 * 4000);
        errors++;
        conclude();
    end

    initial begin
        repeat (12) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_sdram();
        t_io();
        t_wait();
        t_narrow();
        conclude();
    end
endmodule : emp_pins_tb
`default_nettype wire
